// [pdc_regs.svh]
// Register offsets, field positions, reset values and command codes of the pad drive block
// Notes on behaviour
// R1 - Drive strength of data, interrupt, aux and clock outputs set by register 0x03.
// R2 - Bits 7:6 set general output drive, codes 0..3 give 2..8 mA, reset 0.
// R3 - Bits 5:4 set clock output drive, same encoding, reset 1 giving 4 mA.
// R4 - Bits 3:0 are read/write shadow select and clock rate select, used elsewhere.
// R5 - After reset aux outputs 1,2 go to digital ground, 3,4 to analog ground.
// R6 - In power-on state pulls: reset, select up; clock, data in, sleep/tx down.
// R7 - In every other state, reset included, all input pulls are disconnected.
// R8 - Host should turn the clock output off at init when unused.
// R9 - Access starts with MSB-first command byte: 10 read, 11 write, low six bits address.
// R10 - A read returns the last written field values, else the reset values.
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH
`define PDC_CTRL_ADDR     6'h03
`define PDC_CTRL_RST      8'h10
`define PDC_IO_DRV_HI     7
`define PDC_IO_DRV_LO     6
`define PDC_CLK_DRV_HI    5
`define PDC_CLK_DRV_LO    4
`define PDC_SHA_SEL_BIT   3
`define PDC_RATE_HI       2
`define PDC_RATE_LO       0
`define PDC_CMD_RD        2'h2
`define PDC_CMD_WR        2'h3
`define PDC_UNMAPPED_RD   8'h00
`define PDC_BIT_LAST      3'h7
`endif

// [pdc_pkg.sv]
// Types shared by the pad drive configuration block
package pdc_pkg;
   typedef enum logic [1:0] {PDC_DRV_2MA, PDC_DRV_4MA, PDC_DRV_6MA, PDC_DRV_8MA} pdc_drive_t;
   typedef enum {PDC_ST_CMD, PDC_ST_DATA, PDC_ST_SKIP} pdc_state_t;
endpackage

// [pdc_top.sv]
// Pad drive configuration register with its mode-0 serial slave and pad control outputs
`timescale 1ns/1ps
`include "pdc_regs.svh"
module pdc_top (
   // Clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                rst_n_i,
   // Serial slave
   input  wire logic                sel_n_i,
   input  wire logic                sclk_i,
   input  wire logic                mosi_i,
   output logic                     miso_o,
   output logic                     miso_oe_n_o,
   // Transceiver state
   input  wire logic                pon_state_i,
   // Pad drive settings
   output pdc_pkg::pdc_drive_t      io_drive_o,
   output pdc_pkg::pdc_drive_t      clk_drive_o,
   output logic                     clock_out_shadow_select_o,
   output logic [2:0]               clock_out_rate_select_o,
   // Aux outputs, bits 0..3 are aux_out_1..aux_out_4
   output logic [3:0]               aux_out_o,
   output logic [3:0]               aux_oe_n_o,
   // Input pulls: up {reset, select}, down {clock, data in, sleep_tx_control}
   output logic [1:0]               pull_up_en_o,
   output logic [2:0]               pull_dn_en_o
);

   //----------------------------------------
   // Reset release
   //----------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_sync_n;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_r[1];

   //----------------------------------------
   // Address decode
   //----------------------------------------
   function automatic logic pdc_hit(input logic [5:0] addr);
      pdc_hit = (addr == `PDC_CTRL_ADDR);
   endfunction

   //----------------------------------------
   // Serial framing
   //----------------------------------------
   pdc_pkg::pdc_state_t state_r;
   logic                sclk_q_r;
   logic [2:0]          bit_cnt_r;
   logic [6:0]          rx_sh_r;
   logic [7:0]          rx_nxt;
   logic [7:0]          cmd_r;
   logic [7:0]          tx_sh_r;
   logic [7:0]          ctrl_r;
   logic                sclk_rise;
   logic                sclk_fall;
   logic                byte_done;
   logic                wr_stb;
   logic                rd_load;

   assign sclk_rise = !sel_n_i && sclk_i && !sclk_q_r;
   assign sclk_fall = !sel_n_i && !sclk_i && sclk_q_r;
   assign rx_nxt    = {rx_sh_r, mosi_i};
   assign byte_done = sclk_rise && (bit_cnt_r == `PDC_BIT_LAST);
   // Command byte is MSB first, top two bits select the access [R9]
   assign rd_load   = byte_done && (state_r == pdc_pkg::PDC_ST_CMD) && (rx_nxt[7:6] == `PDC_CMD_RD);
   assign wr_stb    = byte_done && (state_r == pdc_pkg::PDC_ST_DATA) && pdc_hit(cmd_r[5:0]); // [R1]

   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sclk_q_r <= 1'b0;
      end else begin
         sclk_q_r <= sclk_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r   <= 7'h00;
      end else if (sel_n_i) begin
         bit_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_sh_r   <= rx_nxt[6:0];
      end
   end

   // Only one register access per select; later bytes are ignored
   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_r <= pdc_pkg::PDC_ST_CMD;
         cmd_r   <= 8'h00;
      end else if (sel_n_i) begin
         state_r <= pdc_pkg::PDC_ST_CMD;
      end else if (byte_done) begin
         unique case (state_r)
            pdc_pkg::PDC_ST_CMD: begin
               cmd_r   <= rx_nxt;
               state_r <= (rx_nxt[7:6] == `PDC_CMD_WR) ? pdc_pkg::PDC_ST_DATA : pdc_pkg::PDC_ST_SKIP; // [R9]
            end
            pdc_pkg::PDC_ST_DATA: begin
               state_r <= pdc_pkg::PDC_ST_SKIP;
            end
            pdc_pkg::PDC_ST_SKIP: begin
               state_r <= pdc_pkg::PDC_ST_SKIP;
            end
         endcase
      end
   end

   //----------------------------------------
   // Control register
   //----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl_r <= `PDC_CTRL_RST; // [R2] [R3]
      end else if (wr_stb) begin
         ctrl_r <= rx_nxt; // [R4]
      end
   end

   assign io_drive_o                = pdc_pkg::pdc_drive_t'(ctrl_r[`PDC_IO_DRV_HI:`PDC_IO_DRV_LO]); // [R2]
   assign clk_drive_o               = pdc_pkg::pdc_drive_t'(ctrl_r[`PDC_CLK_DRV_HI:`PDC_CLK_DRV_LO]); // [R3]
   assign clock_out_shadow_select_o = ctrl_r[`PDC_SHA_SEL_BIT]; // [R4]
   assign clock_out_rate_select_o   = ctrl_r[`PDC_RATE_HI:`PDC_RATE_LO]; // [R4]

   //----------------------------------------
   // Read data out
   //----------------------------------------
   // Output changes on falling clock so the host samples it stable on the rise
   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_sh_r     <= 8'h00;
         miso_o      <= 1'b0;
         miso_oe_n_o <= 1'b1;
      end else begin
         miso_oe_n_o <= sel_n_i;
         if (sel_n_i) begin
            tx_sh_r <= 8'h00;
            miso_o  <= 1'b0;
         end else if (rd_load) begin
            tx_sh_r <= pdc_hit(rx_nxt[5:0]) ? ctrl_r : `PDC_UNMAPPED_RD; // [R10]
         end else if (sclk_fall) begin
            miso_o  <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
      end
   end

   //----------------------------------------
   // Aux outputs and input pulls
   //----------------------------------------
   // Aux pins stay grounded; other uses belong to blocks outside this one
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_aux
         always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
               aux_out_o[gi]  <= 1'b0;
               aux_oe_n_o[gi] <= 1'b0;
            end else begin
               aux_out_o[gi]  <= 1'b0; // [R5]
               aux_oe_n_o[gi] <= 1'b0; // [R5]
            end
         end
      end
   endgenerate

   // Pulls off in reset, so the reset state never keeps them connected
   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pull_up_en_o <= 2'h0; // [R7]
         pull_dn_en_o <= 3'h0;
      end else begin
         pull_up_en_o <= pon_state_i ? 2'h3 : 2'h0; // [R6] [R7]
         pull_dn_en_o <= pon_state_i ? 3'h7 : 3'h0; // [R6] [R7]
      end
   end

   //----------------------------------------
   // Assertions
   //----------------------------------------
   a_write_lands: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R10]
      wr_stb |=> ctrl_r == $past(rx_nxt)) else $error("write data not stored");
   a_reg_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R10]
      !wr_stb |=> $stable(ctrl_r)) else $error("register changed without write");
   a_write_addr_only: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R1]
      wr_stb |-> cmd_r[7:6] == `PDC_CMD_WR && cmd_r[5:0] == `PDC_CTRL_ADDR) else $error("write to wrong address");
   a_reset_value: assert property (@(posedge clk_sys_i) // [R3]
      $rose(rst_sync_n) |-> io_drive_o == pdc_pkg::PDC_DRV_2MA && clk_drive_o == pdc_pkg::PDC_DRV_4MA)
      else $error("bad drive reset value");
   a_aux_ground: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R5]
      aux_out_o == 4'h0 && aux_oe_n_o == 4'h0) else $error("aux output not grounded");
   // Flops still take the reset branch on the edge that releases reset
   a_pull_pon: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R6]
      rst_sync_n && pon_state_i |=> pull_up_en_o == 2'h3 && pull_dn_en_o == 3'h7) else $error("pulls missing");
   a_pull_off: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R7]
      !pon_state_i |=> pull_up_en_o == 2'h0 && pull_dn_en_o == 3'h0) else $error("pulls left on");
   a_read_load: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R9]
      rd_load && pdc_hit(rx_nxt[5:0]) |=> tx_sh_r == $past(ctrl_r)) else $error("read data wrong");
   a_miso_release: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R9]
      sel_n_i |=> miso_oe_n_o && !miso_o) else $error("miso driven while deselected");
   a_miso_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R9]
      !sel_n_i |=> !miso_oe_n_o) else $error("miso not driven while selected");
   a_cmd_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_sync_n) // [R9]
      !sel_n_i && state_r == pdc_pkg::PDC_ST_CMD |-> !miso_o) else $error("miso not low during command byte");

   c_write: cover property (@(posedge clk_sys_i) disable iff (!rst_sync_n) wr_stb);
   c_read_hit: cover property (@(posedge clk_sys_i) disable iff (!rst_sync_n) rd_load && pdc_hit(rx_nxt[5:0]));
   c_pon_exit: cover property (@(posedge clk_sys_i) disable iff (!rst_sync_n) pon_state_i ##1 !pon_state_i);
   c_read_miss: cover property (@(posedge clk_sys_i) disable iff (!rst_sync_n) rd_load && !pdc_hit(rx_nxt[5:0]));

endmodule // pdc_top

// [pdc_host_model.sv]
// Host serial master model driving the pad drive block
`timescale 1ns/1ps
module pdc_host_model (
   // Clock
   input  wire logic clk_sys_i,
   // Serial master pins
   output logic      sel_n_o,
   output logic      sclk_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sel_n_o = 1'b1;
      sclk_o  = 1'b0;
      mosi_o  = 1'b0;
   end
   // ----------------------------------------
   // One framed access: command then data
   // ----------------------------------------
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, dat};
      rd = 8'h00;
      @(posedge clk_sys_i) sel_n_o <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk_sys_i) mosi_o <= sh[i];
         repeat (2) @(posedge clk_sys_i);
         if (i < 8) rd[i] = miso_i;
         sclk_o <= 1'b1;
         repeat (3) @(posedge clk_sys_i);
         sclk_o <= 1'b0;
      end
      // Released data line must not keep showing the last bit
      @(posedge clk_sys_i) sel_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (3) @(posedge clk_sys_i);
   endtask
endmodule // pdc_host_model

// [test_pad_drive_config.sv]
// Self-checking testbench of the pad drive configuration block
`timescale 1ns/1ps
`include "pdc_regs.svh"
module test_pad_drive_config;
   logic                clk_sys_i;
   logic                rst_n_i;
   logic                sel_n_i;
   logic                sclk_i;
   logic                mosi_i;
   logic                miso_o;
   logic                miso_oe_n_o;
   logic                pon_state_i;
   pdc_pkg::pdc_drive_t io_drive_o;
   pdc_pkg::pdc_drive_t clk_drive_o;
   logic                clock_out_shadow_select_o;
   logic [2:0]          clock_out_rate_select_o;
   logic [3:0]          aux_out_o;
   logic [3:0]          aux_oe_n_o;
   logic [1:0]          pull_up_en_o;
   logic [2:0]          pull_dn_en_o;
   int                  failures;
   int                  cmp_count;
   int                  cycles;
   logic [7:0]          rd;
   logic [7:0]          v;

   pdc_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i),
      .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .pon_state_i(pon_state_i),
      .io_drive_o(io_drive_o), .clk_drive_o(clk_drive_o),
      .clock_out_shadow_select_o(clock_out_shadow_select_o),
      .clock_out_rate_select_o(clock_out_rate_select_o), .aux_out_o(aux_out_o),
      .aux_oe_n_o(aux_oe_n_o), .pull_up_en_o(pull_up_en_o), .pull_dn_en_o(pull_dn_en_o));
   pdc_host_model host (.clk_sys_i(clk_sys_i), .sel_n_o(sel_n_i), .sclk_o(sclk_i),
      .mosi_o(mosi_i), .miso_i(miso_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, well above the roughly 1500 cycles the sequence needs
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("[ERR] %0t run did not complete", $time);
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      failures = 0; cmp_count = 0; cycles = 0;
      rst_n_i <= 1'b0;
      pon_state_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      chk({3'h0, pull_up_en_o, pull_dn_en_o}, 8'h00);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      chk({3'h0, pull_up_en_o, pull_dn_en_o}, 8'h1F);
      chk({aux_out_o, aux_oe_n_o}, 8'h00);
      chk({io_drive_o, clk_drive_o, clock_out_shadow_select_o, clock_out_rate_select_o}, 8'h10);
      chk({7'h00, miso_oe_n_o}, 8'h01);
      host.xfer({`PDC_CMD_RD, `PDC_CTRL_ADDR}, 8'h00, rd);
      chk(rd, 8'h10);
      pon_state_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk({3'h0, pull_up_en_o, pull_dn_en_o}, 8'h00);
      // Clock output rate cleared at init since it is unused here
      host.xfer({`PDC_CMD_WR, `PDC_CTRL_ADDR}, 8'h10, rd);
      chk({io_drive_o, clk_drive_o, clock_out_shadow_select_o, clock_out_rate_select_o}, 8'h10);
      for (int k = 0; k < 4; k++) begin
         v = {2'(k), 2'(3 - k), 4'(k * 5)};
         host.xfer({`PDC_CMD_WR, `PDC_CTRL_ADDR}, v, rd);
         chk({io_drive_o, clk_drive_o, clock_out_shadow_select_o, clock_out_rate_select_o}, v);
         host.xfer({`PDC_CMD_RD, `PDC_CTRL_ADDR}, 8'h00, rd);
         chk(rd, v);
      end
      // Other address and non-register command must leave it alone
      host.xfer(8'hC4, 8'h00, rd);
      host.xfer(8'h43, 8'h00, rd);
      host.xfer({`PDC_CMD_RD, `PDC_CTRL_ADDR}, 8'h00, rd);
      chk(rd, 8'hCF);
      host.xfer(8'h84, 8'h00, rd);
      chk(rd, 8'h00);
      // Second reset in mid-run must restore the reset value
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk({io_drive_o, clk_drive_o, clock_out_shadow_select_o, clock_out_rate_select_o}, 8'h10);
      chk({3'h0, pull_up_en_o, pull_dn_en_o}, 8'h00);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      host.xfer({`PDC_CMD_RD, `PDC_CTRL_ADDR}, 8'h00, rd);
      chk(rd, 8'h10);
      tally_and_finish();
   end
endmodule // test_pad_drive_config
